/* File: pkg/swc_regs.svh */
// Register map, option byte layout and timing figures of the standby/wake clock block.
// Assumes a 50 MHz mclk; included by bare name wherever these constants are needed.
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH
// Register port addresses
`define SWC_ADDR_CTRL 8'h00
`define SWC_ADDR_STAB 8'h04
`define SWC_ADDR_STAT 8'h08
`define SWC_ADDR_OPT 8'hC2
// Option byte locations in flash (normal and swapped boot)
`define SWC_OPT_PRI_ADDR 20'h000C2
`define SWC_OPT_ALT_ADDR 20'h010C2
// Option byte fields
`define SWC_OPT_MODE_MSB 7
`define SWC_OPT_MODE_LSB 6
`define SWC_OPT_FIX1_BIT 5
`define SWC_OPT_FIX0_BIT 4
`define SWC_OPT_FREQ_MSB 3
`define SWC_OPT_FREQ_LSB 0
`define SWC_MODE_LV 2'h0
`define SWC_MODE_LS 2'h2
`define SWC_MODE_HS 2'h3
// Oscillator frequency codes and their value in MHz
`define SWC_FRQ_32 4'h8
`define SWC_FRQ_24 4'h0
`define SWC_FRQ_16 4'h9
`define SWC_FRQ_12 4'h1
`define SWC_FRQ_8 4'hA
`define SWC_FRQ_4 4'hB
`define SWC_FRQ_1 4'hD
`define SWC_MHZ_32 6'h20
`define SWC_MHZ_24 6'h18
`define SWC_MHZ_16 6'h10
`define SWC_MHZ_12 6'h0C
`define SWC_MHZ_8 6'h08
`define SWC_MHZ_4 6'h04
`define SWC_MHZ_1 6'h01
`define SWC_MHZ_NONE 6'h00
// Status register fields
`define SWC_STAT_ST_MSB 2
`define SWC_STAT_RDY_BIT 4
`define SWC_STAT_ERR_BIT 5
// Reset values of software registers
`define SWC_CTRL_RST 12'h000
`define SWC_STAB_RST 16'h0000
// Timing: clock rate and times in ns
`define SWC_CLK_MHZ 50
`define SWC_HALT_MIN_NS 18000
`define SWC_HALT_MAX_NS 65000
`define SWC_SZX_HS_NS 4990
`define SWC_SZX_LS_NS 1100
`define SWC_SZX_LV_NS 16580
`define SWC_CYC_UP(ns) ((((ns) * `SWC_CLK_MHZ) + 999) / 1000)
`define SWC_CYC_DN(ns) (((ns) * `SWC_CLK_MHZ) / 1000)
// Wait clocks after the clock supply resumes
`define SWC_WAIT_XT_VEC 16'h000A
`define SWC_WAIT_XT_NV 16'h0004
`define SWC_WAIT_EXT_VEC 16'h0007
`define SWC_WAIT_EXT_NV 16'h0001
`define SWC_WAIT_SZX 16'h0007
`endif

/* File: pkg/swc_pkg.sv */
// Types shared by the standby/wake clock block.
// Assumes nothing beyond a SystemVerilog compiler.
package swc_pkg;
    // Source of the CPU clock
    typedef enum logic [1:0] {SWC_SRC_XTAL, SWC_SRC_EXT, SWC_SRC_ONCHIP} swc_clk_src_t;
    // Flash operating mode from the option byte
    typedef enum logic [1:0] {SWC_FM_LV, SWC_FM_LS, SWC_FM_HS} swc_flash_mode_t;
    // Power sequencer states
    typedef enum logic [2:0] {
        ST_RUN, ST_STOP, ST_HALT, ST_WAIT, ST_TO_SNZ, ST_SNOOZE, ST_SNZ_EXIT
    } swc_pm_state_t;
    // Option loader states
    typedef enum logic [2:0] {LD_SYNC0, LD_SYNC1, LD_ISSUE, LD_WAIT, LD_DONE} swc_ld_state_t;
endpackage : swc_pkg

/* File: rtl/swc_delay_timer.sv */
// Down counter that times one phase of the power sequencer.
// Assumes the load value is held only in the cycle of load.
`timescale 1ns/1ns
module swc_delay_timer (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [15:0] load_val,
    output logic done
);
    import swc_pkg::*;
    // Timer state
    typedef struct packed {
        logic [15:0] cnt;
        logic done;
    } swc_tmr_st_t;
    swc_tmr_st_t tmr_reg, tmr_next;

    // Done comes load_val+1 edges after load, so zero gives one cycle
    always_comb begin
        tmr_next = tmr_reg;
        if (load) begin
            tmr_next.cnt = load_val;
            tmr_next.done = (load_val == 16'h0000);
        end else begin
            tmr_next.done = (tmr_reg.cnt == 16'h0001);
            if (tmr_reg.cnt != 16'h0000) begin
                tmr_next.cnt = tmr_reg.cnt - 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign done = tmr_reg.done;
endmodule : swc_delay_timer

/* File: rtl/swc_opt_loader.sv */
// Fetches and decodes the configuration option byte from flash after reset.
// Assumes flash answers a one-cycle read request with a one-cycle valid pulse.
`timescale 1ns/1ns
`include "swc_regs.svh"
module swc_opt_loader (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic boot_swap,
    input wire logic [7:0] nvm_rd_data,
    input wire logic nvm_rd_valid,
    output logic nvm_rd_req,
    output logic [19:0] nvm_addr,
    output logic [7:0] opt_byte,
    output swc_pkg::swc_flash_mode_t flash_mode,
    output logic [5:0] osc_freq_mhz,
    output logic opt_ready,
    output logic opt_err
);
    import swc_pkg::*;
    // Loader state, boot swap strap synchroniser included
    typedef struct packed {
        swc_ld_state_t st;
        logic swap_s1;
        logic swap_s2;
        logic req;
        logic [19:0] addr;
        logic [7:0] byte_v;
        swc_flash_mode_t mode;
        logic [5:0] mhz;
        logic ready;
        logic err;
    } swc_ld_st_t;
    swc_ld_st_t ld_reg, ld_next;
    logic [1:0] mode_code;
    logic [3:0] freq_code;

    assign mode_code = nvm_rd_data[`SWC_OPT_MODE_MSB:`SWC_OPT_MODE_LSB];
    assign freq_code = nvm_rd_data[`SWC_OPT_FREQ_MSB:`SWC_OPT_FREQ_LSB];

    // Sequence: let the strap settle, read once, decode
    always_comb begin
        ld_next = ld_reg;
        ld_next.swap_s1 = boot_swap;
        ld_next.swap_s2 = ld_reg.swap_s1;
        ld_next.req = 1'b0;
        case (ld_reg.st)
            LD_SYNC0: ld_next.st = LD_SYNC1;
            LD_SYNC1: ld_next.st = LD_ISSUE;
            LD_ISSUE: begin
                ld_next.req = 1'b1;
                ld_next.addr = ld_reg.swap_s2 ? `SWC_OPT_ALT_ADDR : `SWC_OPT_PRI_ADDR;
                ld_next.st = LD_WAIT;
            end
            LD_WAIT: if (nvm_rd_valid) begin
                ld_next.byte_v = nvm_rd_data;
                ld_next.ready = 1'b1;
                ld_next.st = LD_DONE;
                ld_next.err = 1'b0;
                case (mode_code)
                    `SWC_MODE_LV: ld_next.mode = SWC_FM_LV;
                    `SWC_MODE_LS: ld_next.mode = SWC_FM_LS;
                    `SWC_MODE_HS: ld_next.mode = SWC_FM_HS;
                    default: begin
                        ld_next.mode = SWC_FM_LV;
                        ld_next.err = 1'b1;
                    end
                endcase
                case (freq_code)
                    `SWC_FRQ_32: ld_next.mhz = `SWC_MHZ_32;
                    `SWC_FRQ_24: ld_next.mhz = `SWC_MHZ_24;
                    `SWC_FRQ_16: ld_next.mhz = `SWC_MHZ_16;
                    `SWC_FRQ_12: ld_next.mhz = `SWC_MHZ_12;
                    `SWC_FRQ_8: ld_next.mhz = `SWC_MHZ_8;
                    `SWC_FRQ_4: ld_next.mhz = `SWC_MHZ_4;
                    `SWC_FRQ_1: ld_next.mhz = `SWC_MHZ_1;
                    default: begin
                        ld_next.mhz = `SWC_MHZ_NONE;
                        ld_next.err = 1'b1;
                    end
                endcase
                // fixed bits checked, flagged if wrong
                if (!nvm_rd_data[`SWC_OPT_FIX1_BIT] || nvm_rd_data[`SWC_OPT_FIX0_BIT]) begin
                    ld_next.err = 1'b1;
                end
            end
            LD_DONE: ld_next.st = LD_DONE;
            default: ld_next.st = LD_SYNC0;
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ld_reg <= '0;
        end else begin
            ld_reg <= ld_next;
        end
    end

    assign nvm_rd_req = ld_reg.req;
    assign nvm_addr = ld_reg.addr;
    assign opt_byte = ld_reg.byte_v;
    assign flash_mode = ld_reg.mode;
    assign osc_freq_mhz = ld_reg.mhz;
    assign opt_ready = ld_reg.ready;
    assign opt_err = ld_reg.err;

    AST_OPT_SRC: assert property (@(posedge mclk) disable iff (!resetn)
        nvm_rd_req |-> nvm_addr == ($past(ld_reg.swap_s2) ? `SWC_OPT_ALT_ADDR : `SWC_OPT_PRI_ADDR))
        else $error("option byte read from wrong location");
endmodule : swc_opt_loader

/* File: rtl/swc_top.sv */
// Standby/wake clock sequencer: stop release, snooze entry and exit, option byte.
// Assumes wake, snooze and stop requests come from logic on mclk; boot_swap is a pin.
`timescale 1ns/1ns
`include "swc_regs.svh"
module swc_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic stop_req,
    input wire logic wake_req,
    input wire logic wake_vectored,
    input wire logic snooze_req,
    input wire logic snooze_done,
    input wire swc_pkg::swc_clk_src_t cpu_clk_src,
    input wire logic boot_swap,
    output logic nvm_rd_req,
    output logic [19:0] nvm_addr,
    input wire logic [7:0] nvm_rd_data,
    input wire logic nvm_rd_valid,
    output logic clk_supply_en,
    output logic cpu_resume,
    output logic vector_fetch,
    output logic snooze_active,
    output logic stop_active,
    output swc_pkg::swc_flash_mode_t flash_mode,
    output logic [5:0] osc_freq_mhz,
    output logic opt_ready,
    output logic opt_err
);
    import swc_pkg::*;

    // ----------------------------------------------------------------
    // Timing constants
    // ----------------------------------------------------------------
    // Halt bounds: least time rounds up, longest rounds down
    localparam logic [15:0] HALT_MIN_CYC = 16'(`SWC_CYC_UP(`SWC_HALT_MIN_NS));
    localparam logic [15:0] HALT_MAX_CYC = 16'(`SWC_CYC_DN(`SWC_HALT_MAX_NS));
    // Snooze exit delays, taken at their least value
    localparam logic [15:0] SZX_HS_CYC = 16'(`SWC_CYC_UP(`SWC_SZX_HS_NS));
    localparam logic [15:0] SZX_LS_CYC = 16'(`SWC_CYC_UP(`SWC_SZX_LS_NS));
    localparam logic [15:0] SZX_LV_CYC = 16'(`SWC_CYC_UP(`SWC_SZX_LV_NS));

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // All flops of the sequencer and register file
    typedef struct packed {
        swc_pm_state_t st;
        logic [11:0] halt_trim;
        logic [15:0] stab;
        logic vec;
        logic clk_en;
        logic resume;
        logic vfetch;
        logic snz;
        logic stopped;
        logic [15:0] rdata;
    } swc_top_st_t;
    swc_top_st_t top_reg, top_next;

    // Timer handshake: load and value combinational from the sequencer, done from the timer flop
    logic tmr_load;
    logic [15:0] tmr_val;
    logic tmr_done;
    // Option byte as stored by the loader
    logic [7:0] opt_byte;
    // Derived lengths of each phase
    logic [15:0] trim_ext;
    logic [15:0] halt_hi;
    logic [15:0] halt_len;
    logic [15:0] snz_len;
    logic [15:0] wait_len;
    logic [15:0] szx_len;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    // One shared timer; phases never overlap
    swc_delay_timer u_timer (
        .mclk(mclk),
        .resetn(resetn),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // Option byte fetch and decode after reset
    swc_opt_loader u_loader (
        .mclk(mclk),
        .resetn(resetn),
        .boot_swap(boot_swap),
        .nvm_rd_data(nvm_rd_data),
        .nvm_rd_valid(nvm_rd_valid),
        .nvm_rd_req(nvm_rd_req),
        .nvm_addr(nvm_addr),
        .opt_byte(opt_byte),
        .flash_mode(flash_mode),
        .osc_freq_mhz(osc_freq_mhz),
        .opt_ready(opt_ready),
        .opt_err(opt_err)
    );

    // ----------------------------------------------------------------
    // Phase lengths
    // ----------------------------------------------------------------
    // Software trims the halt inside the legal window; the real part varies
    // with temperature and stop time, so any point of the window is valid
    always_comb begin
        trim_ext = {4'h0, top_reg.halt_trim};
        // crystal upper bound stretches to the stabilisation time
        if (cpu_clk_src == SWC_SRC_XTAL && top_reg.stab > HALT_MAX_CYC) begin
            halt_hi = top_reg.stab;
        end else begin
            halt_hi = HALT_MAX_CYC;
        end
        if (trim_ext < HALT_MIN_CYC) begin
            halt_len = HALT_MIN_CYC;
        end else if (trim_ext > halt_hi) begin
            halt_len = halt_hi;
        end else begin
            halt_len = trim_ext;
        end
        // snooze entry uses the fixed window
        if (trim_ext < HALT_MIN_CYC) begin
            snz_len = HALT_MIN_CYC;
        end else if (trim_ext > HALT_MAX_CYC) begin
            snz_len = HALT_MAX_CYC;
        end else begin
            snz_len = trim_ext;
        end
        if (cpu_clk_src == SWC_SRC_XTAL) begin
            wait_len = top_reg.vec ? `SWC_WAIT_XT_VEC : `SWC_WAIT_XT_NV;
        end else begin
            wait_len = top_reg.vec ? `SWC_WAIT_EXT_VEC : `SWC_WAIT_EXT_NV;
        end
        case (flash_mode)
            SWC_FM_HS: szx_len = SZX_HS_CYC;
            SWC_FM_LS: szx_len = SZX_LS_CYC;
            default: szx_len = SZX_LV_CYC;
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer and register file
    // ----------------------------------------------------------------
    // Timer loads are length minus one: a phase of N lasts N cycles
    always_comb begin
        top_next = top_reg;
        tmr_load = 1'b0;
        tmr_val = 16'h0000;
        top_next.resume = 1'b0;
        top_next.vfetch = 1'b0;
        top_next.rdata = 16'h0000;
        // Register writes; unmapped addresses are ignored
        if (wr) begin
            case (addr)
                `SWC_ADDR_CTRL: top_next.halt_trim = wdata[11:0];
                `SWC_ADDR_STAB: top_next.stab = wdata;
                default: ;
            endcase
        end
        // Register reads; unmapped addresses return zero
        if (rd) begin
            case (addr)
                `SWC_ADDR_CTRL: top_next.rdata = trim_ext;
                `SWC_ADDR_STAB: top_next.rdata = top_reg.stab;
                `SWC_ADDR_STAT: begin
                    top_next.rdata[`SWC_STAT_ST_MSB:0] = top_reg.st;
                    top_next.rdata[`SWC_STAT_RDY_BIT] = opt_ready;
                    top_next.rdata[`SWC_STAT_ERR_BIT] = opt_err;
                end
                `SWC_ADDR_OPT: top_next.rdata = {8'h00, opt_byte};
                default: top_next.rdata = 16'h0000;
            endcase
        end
        case (top_reg.st)
            // Stop waits for the option byte to be loaded, even one flagged in error
            ST_RUN: begin
                if (stop_req && opt_ready) begin
                    top_next.st = ST_STOP;
                end
            end
            // Wake wins over snooze when both arrive together
            ST_STOP: begin
                if (wake_req) begin
                    top_next.st = ST_HALT;
                    top_next.vec = wake_vectored;
                    tmr_load = 1'b1;
                    tmr_val = halt_len - 16'h0001;
                end else if (snooze_req) begin
                    top_next.st = ST_TO_SNZ;
                    tmr_load = 1'b1;
                    tmr_val = snz_len - 16'h0001;
                end
            end
            ST_HALT: begin
                if (tmr_done) begin
                    top_next.st = ST_WAIT;
                    tmr_load = 1'b1;
                    tmr_val = wait_len - 16'h0001;
                end
            end
            ST_WAIT: begin
                if (tmr_done) begin
                    top_next.st = ST_RUN;
                    top_next.resume = 1'b1;
                    top_next.vfetch = top_reg.vec;
                end
            end
            ST_TO_SNZ: begin
                if (tmr_done) begin
                    top_next.st = ST_SNOOZE;
                end
            end
            // Interrupt leaves snooze, snooze done goes back to stop
            ST_SNOOZE: begin
                if (wake_req) begin
                    top_next.st = ST_SNZ_EXIT;
                    top_next.vec = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = szx_len - 16'h0001;
                end else if (snooze_done) begin
                    top_next.st = ST_STOP;
                end
            end
            ST_SNZ_EXIT: begin
                if (tmr_done) begin
                    top_next.st = ST_WAIT;
                    tmr_load = 1'b1;
                    tmr_val = `SWC_WAIT_SZX - 16'h0001;
                end
            end
            default: top_next.st = ST_RUN;
        endcase
        // clock supply off except while running or waiting
        top_next.clk_en = (top_next.st == ST_RUN) || (top_next.st == ST_WAIT);
        top_next.snz = (top_next.st == ST_SNOOZE);
        top_next.stopped = (top_next.st == ST_STOP) || (top_next.st == ST_HALT)
            || (top_next.st == ST_TO_SNZ);
    end

    // State register; clock supply on from reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            top_reg <= '0;
            top_reg.st <= ST_RUN;
            top_reg.clk_en <= 1'b1;
            top_reg.halt_trim <= `SWC_CTRL_RST;
            top_reg.stab <= `SWC_STAB_RST;
        end else begin
            top_reg <= top_next;
        end
    end

    // Outputs straight from flops
    assign rdata = top_reg.rdata;
    assign clk_supply_en = top_reg.clk_en;
    assign cpu_resume = top_reg.resume;
    assign vector_fetch = top_reg.vfetch;
    assign snooze_active = top_reg.snz;
    assign stop_active = top_reg.stopped;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Cycles spent in the current state, for the checks only
    logic [15:0] dwell;
    logic leaving;
    assign leaving = (top_next.st != top_reg.st);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dwell <= 16'h0001;
        end else if (leaving) begin
            dwell <= 16'h0001;
        end else if (dwell != 16'hFFFF) begin
            dwell <= dwell + 16'h0001;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Wait phases that end in resume
    // Ten wait cycles, split in two runs of five to keep each repetition short
    sequence s_wait10;
        (top_reg.st == ST_WAIT) [*5] ##1 (top_reg.st == ST_WAIT) [*5]
        ##1 (cpu_resume && vector_fetch);
    endsequence
    sequence s_wait4;
        (top_reg.st == ST_WAIT) [*4] ##1 (cpu_resume && !vector_fetch);
    endsequence
    sequence s_wait7;
        (top_reg.st == ST_WAIT) [*7] ##1 (cpu_resume && vector_fetch);
    endsequence
    sequence s_wait1;
        (top_reg.st == ST_WAIT) ##1 (cpu_resume && !vector_fetch);
    endsequence
    sequence s_halt_end;
        top_reg.st == ST_HALT && leaving;
    endsequence

    AST_HALT_XTAL: assert property (
        s_halt_end and (cpu_clk_src == SWC_SRC_XTAL) |->
        dwell >= HALT_MIN_CYC && dwell <= halt_hi)
        else $error("crystal halt outside window");
    AST_WAIT_XTAL: assert property (
        s_halt_end and (cpu_clk_src == SWC_SRC_XTAL) |=>
        if (top_reg.vec) s_wait10 else s_wait4)
        else $error("crystal wait count wrong");
    AST_HALT_EXT: assert property (
        s_halt_end and (cpu_clk_src != SWC_SRC_XTAL) |->
        dwell >= HALT_MIN_CYC && dwell <= HALT_MAX_CYC)
        else $error("halt outside 18 to 65 us");
    AST_WAIT_EXT: assert property (
        s_halt_end and (cpu_clk_src != SWC_SRC_XTAL) |=>
        if (top_reg.vec) s_wait7 else s_wait1)
        else $error("external clock wait count wrong");
    AST_HALT_NOCLK: assert property (
        (top_reg.st == ST_HALT) |-> !clk_supply_en && !cpu_resume)
        else $error("clock supplied during halt");
    AST_SNZ_ENTRY: assert property (
        (top_reg.st == ST_TO_SNZ && leaving) |->
        dwell >= HALT_MIN_CYC && dwell <= HALT_MAX_CYC ##1 snooze_active)
        else $error("snooze entry time wrong");
    AST_SNZ_EXIT: assert property (
        (top_reg.st == ST_SNZ_EXIT && leaving) |->
        dwell == szx_len ##1 s_wait7)
        else $error("snooze exit time wrong");
    AST_OPT_MODE: assert property (
        $rose(opt_ready) && !opt_err |->
        opt_byte[`SWC_OPT_MODE_MSB:`SWC_OPT_MODE_LSB] != 2'h1)
        else $error("prohibited flash mode accepted");
    AST_OPT_FREQ: assert property (
        opt_ready && !opt_err |-> osc_freq_mhz != `SWC_MHZ_NONE)
        else $error("prohibited oscillator code accepted");
    AST_RESUME_AFTER_CLK: assert property (
        cpu_resume |-> $past(clk_supply_en) && $past(top_reg.st) == ST_WAIT)
        else $error("resume before clock supply");
endmodule : swc_top

/* File: dv/testbench.sv */
// Self-checking bench for the standby/wake clock block.
// Assumes swc_top alone on a 50 MHz mclk; the bench plays flash and CPU.
`timescale 1ns/1ns
`include "swc_regs.svh"
module testbench;
import swc_pkg::*;
logic mclk = 0, resetn = 0, wr = 0, rd = 0, stop_req = 0, wake_req = 0;
logic wake_vectored = 0, snooze_req = 0, snooze_done = 0, boot_swap = 0;
logic nvm_rd_valid = 0, nvm_rd_req, clk_supply_en, cpu_resume, vector_fetch;
logic snooze_active, stop_active, opt_ready, opt_err;
logic [7:0] addr = 0, nvm_rd_data = 0;
logic [15:0] wdata = 0, rdata, v;
logic [19:0] nvm_addr;
logic [5:0] osc_freq_mhz;
logic [31:0] seed = 99;
swc_clk_src_t cpu_clk_src = SWC_SRC_EXT;
swc_flash_mode_t flash_mode;
int fails = 0, checks = 0, n, on, t, st, h, hi, w;
swc_top u_swc_top (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .stop_req(stop_req), .wake_req(wake_req), .wake_vectored(wake_vectored),
    .snooze_req(snooze_req), .snooze_done(snooze_done), .cpu_clk_src(cpu_clk_src),
    .boot_swap(boot_swap), .nvm_rd_req(nvm_rd_req), .nvm_addr(nvm_addr),
    .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid), .clk_supply_en(clk_supply_en),
    .cpu_resume(cpu_resume), .vector_fetch(vector_fetch), .snooze_active(snooze_active),
    .stop_active(stop_active), .flash_mode(flash_mode), .osc_freq_mhz(osc_freq_mhz),
    .opt_ready(opt_ready), .opt_err(opt_err)
);
// Free running clock
always #10 mclk = ~mclk;
function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
endfunction : xs
// Oscillator code to MHz, zero when prohibited
function automatic logic [5:0] mhz(input logic [3:0] c);
    case (c)
        4'h8: return 6'h20;
        4'h0: return 6'h18;
        4'h9: return 6'h10;
        4'h1: return 6'h0C;
        4'hA: return 6'h08;
        4'hB: return 6'h04;
        4'hD: return 6'h01;
        default: return 6'h00;
    endcase
endfunction : mhz
task chk(input string s, input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
        fails++;
        $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
endtask : chk
task conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask : conclude
// Reset, then answer the single option byte read
task boot(input logic [7:0] ob, input logic sw);
    resetn <= 0;
    boot_swap <= sw;
    repeat (16) @(posedge mclk);
    resetn <= 1;
    for (n = 0; n < 20 && nvm_rd_req !== 1'b1; n++) @(posedge mclk) #1;
    chk("nvm_addr", nvm_addr, sw ? 20'h010C2 : 20'h000C2);
    @(posedge mclk);
    nvm_rd_valid <= 1;
    nvm_rd_data <= ob;
    @(posedge mclk);
    nvm_rd_valid <= 0;
    // Released data lines show a changed value, not the old byte
    nvm_rd_data <= ~ob;
    @(posedge mclk) #1;
    chk("mode", flash_mode, ob[7:6] == 3 ? 2 : ob[7:6] == 2 ? 1 : 0);
    chk("mhz", osc_freq_mhz, mhz(ob[3:0]));
    chk("err", opt_err, ob[7:6] == 1 || mhz(ob[3:0]) == 0 || ob[5:4] != 2);
endtask : boot
task rdr(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1;
    @(posedge mclk);
    rd <= 0;
    #1 v = rdata;
endtask : rdr
task wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge mclk);
    wr <= 0;
endtask : wrr
// One-cycle request pulse: 0 stop, 1 snooze, 2 wake, 3 snooze done
task req(input int k);
    @(posedge mclk);
    if (k == 0) stop_req <= 1;
    else if (k == 1) snooze_req <= 1;
    else if (k == 2) wake_req <= 1;
    else snooze_done <= 1;
    @(posedge mclk);
    {stop_req, snooze_req, wake_req, snooze_done} <= 4'b0000;
endtask : req
// Count cycles to resume, noting when the clock returns
task waitr;
    on = -1;
    for (n = 0; cpu_resume !== 1'b1 && n < 5000; n++) begin
        @(posedge mclk) #1;
        if (on < 0 && clk_supply_en === 1'b1) on = n + 1;
    end
endtask : waitr
initial begin
    for (int i = 0; i < 3; i++) begin
        seed = xs(seed);
        boot({seed[7:6], 2'b10, seed[3:0]}, seed[8]);
    end
    boot(8'h5D, 0);
    boot(8'hE8, 1);
    rdr(`SWC_ADDR_OPT);
    chk("opt", v, 16'h00E8);
    rdr(8'h10);
    chk("unmapped", v, 16'h0000);
    rdr(`SWC_ADDR_STAT);
    chk("status", v, 16'h0010);
    $display("option byte and register tests done");
    for (int s = 0; s < 6; s++) begin
        seed = xs(seed);
        t = s == 0 ? 0 : s == 1 ? 4095 : seed[11:0];
        st = seed[27:16];
        cpu_clk_src <= swc_clk_src_t'(s / 2);
        wake_vectored <= s[0];
        wrr(`SWC_ADDR_CTRL, t[15:0]);
        wrr(`SWC_ADDR_STAB, st[15:0]);
        rdr(`SWC_ADDR_STAB);
        chk("stab", v, st[15:0]);
        req(0);
        #1 chk("stop", {stop_active, clk_supply_en}, 2'b10);
        req(2);
        waitr;
        hi = (s < 2 && st > 3250) ? st : 3250;
        h = t < 900 ? 900 : t > hi ? hi : t;
        w = s < 2 ? (s[0] ? 10 : 4) : (s[0] ? 7 : 1);
        chk("halt", on, h);
        chk("resume", n, h + w);
        chk("vector", vector_fetch, s[0]);
    end
    $display("stop release tests done");
    // Snooze round trips: trimmed in high-speed mode, then low-speed and low-voltage
    for (int k = 0; k < 3; k++) begin
        if (k > 0) boot(k == 1 ? 8'hA8 : 8'h28, 0);
        req(0);
        req(1);
        for (n = 0; snooze_active !== 1'b1 && n < 5000; n++) @(posedge mclk) #1;
        chk("snooze in", n, k > 0 ? 900 : h);
        if (k == 0) begin
            req(3);
            #1 chk("snooze done", {stop_active, snooze_active}, 2'b10);
            req(1);
            for (n = 0; snooze_active !== 1'b1 && n < 5000; n++) @(posedge mclk) #1;
            chk("snooze again", n, h);
        end
        req(2);
        waitr;
        chk("snooze out", n, (k == 0 ? 250 : k == 1 ? 55 : 829) + 7);
        chk("vector", vector_fetch, 1);
        chk("clock back", on, n - 7);
    end
    $display("snooze tests done");
    conclude;
end
initial begin
    #1500000;
    fails++;
    conclude;
end
endmodule : testbench
